// File: src/ctw_pkg.sv
// constants, types and code classifier shared by the tuple walker files
package ctw_pkg;

    // ----------------------------------------------------------------
    // tuple codes and markers
    // ----------------------------------------------------------------
    localparam logic [7:0] CODE_NULL_ENTRY    = 8'h00;
    localparam logic [7:0] CODE_COMMON_DEV    = 8'h01;
    localparam logic [7:0] CODE_DEV_EXT_LO    = 8'h02;
    localparam logic [7:0] CODE_DEV_EXT_HI    = 8'h07;
    localparam logic [7:0] CODE_CHECKSUM      = 8'h10;
    localparam logic [7:0] CODE_FAR_ATTR      = 8'h11;
    localparam logic [7:0] CODE_FAR_COMMON    = 8'h12;
    localparam logic [7:0] CODE_JUMP_TARGET   = 8'h13;
    localparam logic [7:0] CODE_NO_JUMP       = 8'h14;
    localparam logic [7:0] CODE_PRODUCT_INFO  = 8'h15;
    localparam logic [7:0] CODE_ALT_STRINGS   = 8'h16;
    localparam logic [7:0] CODE_ATTR_DEV      = 8'h17;
    localparam logic [7:0] CODE_COMMON_PROG   = 8'h18;
    localparam logic [7:0] CODE_ATTR_PROG     = 8'h19;
    localparam logic [7:0] CODE_L2_VERSION    = 8'h40;
    localparam logic [7:0] CODE_FORMAT        = 8'h41;
    localparam logic [7:0] CODE_GEOMETRY      = 8'h42;
    localparam logic [7:0] CODE_BYTE_ORDER    = 8'h43;
    localparam logic [7:0] CODE_INIT_DATE     = 8'h44;
    localparam logic [7:0] CODE_BATTERY_DATE  = 8'h45;
    localparam logic [7:0] CODE_DATA_ORG      = 8'h46;
    localparam logic [7:0] CODE_VENDOR_LO     = 8'h80;
    localparam logic [7:0] CODE_END_OF_CHAIN  = 8'hFF;
    localparam logic [7:0] LINK_LAST          = 8'hFF;
    localparam logic [7:0] TERM_BYTE          = 8'hFF;
    // first body byte of a format entry that marks a disk-like format
    localparam logic [7:0] FMT_DISK_TYPE      = 8'h00;

    // ----------------------------------------------------------------
    // addressing and sizes
    // ----------------------------------------------------------------
    localparam int ATTR_ADDR_SHIFT = 1;
    localparam int MAX_BYTES_DEF   = 2048;
    localparam int ADDR_W_DEF      = 26;
    localparam int BUF_DEPTH       = 2;

    // ----------------------------------------------------------------
    // classification
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        CLS_NULL, CLS_COMMON_DEV, CLS_DEV_EXT, CLS_CHECKSUM, CLS_FAR_ATTR,
        CLS_FAR_COMMON, CLS_JUMP_TARGET, CLS_NO_JUMP, CLS_PRODUCT_INFO,
        CLS_ALT_STRINGS, CLS_ATTR_DEV, CLS_COMMON_PROG, CLS_ATTR_PROG,
        CLS_L2_VERSION, CLS_FORMAT, CLS_GEOMETRY, CLS_BYTE_ORDER,
        CLS_INIT_DATE, CLS_BATTERY_DATE, CLS_DATA_ORG, CLS_UNRECOGNIZED,
        CLS_VENDOR, CLS_END
    } ctw_class_t;

    // ----------------------------------------------------------------
    // buffered item layout: hdr, last, class, unrec, vendor, misplaced, link, byte
    // ----------------------------------------------------------------
    localparam int ITEM_BYTE_LSB  = 0;
    localparam int ITEM_LINK_LSB  = 8;
    localparam int ITEM_MISP_BIT  = 16;
    localparam int ITEM_VEND_BIT  = 17;
    localparam int ITEM_UNREC_BIT = 18;
    localparam int ITEM_CLS_LSB   = 19;
    localparam int ITEM_LAST_BIT  = 24;
    localparam int ITEM_HDR_BIT   = 25;
    localparam int ITEM_W         = 26;

    function automatic ctw_class_t ctw_classify(input logic [7:0] code);
        ctw_class_t c;
        c = CLS_UNRECOGNIZED;
        case (code)
            CODE_NULL_ENTRY:   c = CLS_NULL;
            CODE_COMMON_DEV:   c = CLS_COMMON_DEV;
            CODE_CHECKSUM:     c = CLS_CHECKSUM;
            CODE_FAR_ATTR:     c = CLS_FAR_ATTR;
            CODE_FAR_COMMON:   c = CLS_FAR_COMMON;
            CODE_JUMP_TARGET:  c = CLS_JUMP_TARGET;
            CODE_NO_JUMP:      c = CLS_NO_JUMP;
            CODE_PRODUCT_INFO: c = CLS_PRODUCT_INFO;
            CODE_ALT_STRINGS:  c = CLS_ALT_STRINGS;
            CODE_ATTR_DEV:     c = CLS_ATTR_DEV;
            CODE_COMMON_PROG:  c = CLS_COMMON_PROG;
            CODE_ATTR_PROG:    c = CLS_ATTR_PROG;
            CODE_L2_VERSION:   c = CLS_L2_VERSION;
            CODE_FORMAT:       c = CLS_FORMAT;
            CODE_GEOMETRY:     c = CLS_GEOMETRY;
            CODE_BYTE_ORDER:   c = CLS_BYTE_ORDER;
            CODE_INIT_DATE:    c = CLS_INIT_DATE;
            CODE_BATTERY_DATE: c = CLS_BATTERY_DATE;
            CODE_DATA_ORG:     c = CLS_DATA_ORG;
            CODE_END_OF_CHAIN: c = CLS_END;
            default: begin
                if (code >= CODE_DEV_EXT_LO && code <= CODE_DEV_EXT_HI) begin
                    c = CLS_DEV_EXT;
                end else if (code >= CODE_VENDOR_LO) begin
                    c = CLS_VENDOR;
                end else begin
                    c = CLS_UNRECOGNIZED;
                end
            end
        endcase
        return c;
    endfunction

endpackage

// File: src/ctw_skid.sv
// two-entry buffer between the walker and the item consumer
`timescale 1ns/1ns
`default_nettype none
module ctw_skid #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import ctw_pkg::*;

    typedef struct packed {
        logic [1:0]   cnt;
        logic [W-1:0] head;
        logic [W-1:0] tail;
    } ctw_skid_t;

    ctw_skid_t s_q;
    ctw_skid_t s_d;
    logic      push;
    logic      pop;

    initial begin
        if (W < 1) begin
            $error("ctw_skid: width must be positive");
        end
    end

    // ready is a plain decode of the count, so the producer never loses a word
    assign in_ready  = (s_q.cnt != 2'(BUF_DEPTH));
    assign out_valid = (s_q.cnt != 2'h0);
    assign out_data  = s_q.head;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        case ({push, pop})
            2'b10: begin
                if (s_q.cnt == 2'h0) begin
                    s_d.head = in_data;
                end else begin
                    s_d.tail = in_data;
                end
                s_d.cnt = s_q.cnt + 2'h1;
            end
            2'b01: begin
                s_d.head = s_q.tail;
                s_d.cnt  = s_q.cnt - 2'h1;
            end
            2'b11: begin
                if (s_q.cnt == 2'h1) begin
                    s_d.head = in_data;
                end else begin
                    s_d.head = s_q.tail;
                    s_d.tail = in_data;
                end
            end
            default: begin
                s_d = s_q;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    fill_bound_a: assert property (@(posedge clk) disable iff (reset)
        s_q.cnt <= 2'(BUF_DEPTH))
        else $error("buffer count above depth");

endmodule
`default_nettype wire

// File: src/ctw_walker.sv
// card information structure tuple walker over attribute memory space
//
// Contract
// - chain lives at attribute address zero; the walk starts fetching there.
// - first tuple byte is the type code and selects the class.
// - code FFh ends the chain; nothing more is fetched.
// - second byte is body length; next tuple at start plus two plus it.
// - link zero means empty body; next tuple follows the two header bytes.
// - link FFh marks this tuple as the last one; then stop.
// - a tuple is never treated as longer than two plus link bytes.
// - terminator byte may end a body early; reads never go past link length.
// - code 1 common device info, 17h attribute device info, 2-7 extensions.
// - codes 10h to 14h decode as checksum and jump control entries.
// - 15h product text, 16h alt strings, 18h and 19h programming info.
// - codes 40h to 46h decode as recording-format entries.
// - geometry only for disk-like, byte order only memory-like; flag misuse.
// - reserved and incompatible device codes flagged unrecognized, skipped by link.
// - code zero is one byte only; no link byte is read.
// - attribute bytes sit at even addresses; two card addresses per byte.
// - multi-byte body fields are assembled least significant byte first.
`timescale 1ns/1ns
`default_nettype none
module ctw_walker #(
    parameter int MAX_BYTES = ctw_pkg::MAX_BYTES_DEF,
    parameter int ADDR_W    = ctw_pkg::ADDR_W_DEF
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire logic                start,
    output logic                     rd_req,
    output logic [ADDR_W-1:0]        rd_addr,
    input  wire logic                rd_ack,
    input  wire logic [7:0]          rd_data,
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic                     out_hdr,
    output logic                     out_last,
    output ctw_pkg::ctw_class_t      out_class,
    output logic                     out_unrecognized,
    output logic                     out_vendor,
    output logic                     out_misplaced,
    output logic [7:0]               out_link,
    output logic [7:0]               out_byte,
    output logic [15:0]              field_word,
    output logic                     busy,
    output logic                     done,
    output logic                     chain_error
);
    import ctw_pkg::*;

    localparam int POS_W = $clog2(MAX_BYTES + 260);

    initial begin
        if (MAX_BYTES < 2 || ADDR_W < POS_W + ATTR_ADDR_SHIFT) begin
            $error("ctw_walker: size or address width cannot be served");
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_CODE, ST_LINK, ST_HDR, ST_BODY, ST_BPUSH
    } ctw_state_t;

    typedef struct packed {
        ctw_state_t         st;
        logic [POS_W-1:0]   pos;
        logic [POS_W-1:0]   nxt;
        logic [7:0]         code;
        logic [7:0]         link;
        logic [7:0]         cnt;
        logic               fmt_seen;
        logic               fmt_disk;
        logic [15:0]        word;
        logic               item_valid;
        logic [ITEM_W-1:0]  item;
        logic               req;
        logic [ADDR_W-1:0]  addr;
        logic               busy;
        logic               done;
        logic               err;
    } ctw_walk_t;

    ctw_walk_t         s_q;
    ctw_walk_t         s_d;
    logic              buf_ready;
    logic [ITEM_W-1:0] buf_data;
    ctw_class_t        cls;
    logic              misplaced;
    logic              term_type;
    logic              body_end;

    // byte position to card address: even bytes only in attribute space
    function automatic logic [ADDR_W-1:0] card_addr(input logic [POS_W-1:0] p);
        return ADDR_W'(p) << ATTR_ADDR_SHIFT;
    endfunction

    function automatic logic [ITEM_W-1:0] make_item(
        input logic hdr, input logic last, input ctw_class_t c,
        input logic misp, input logic [7:0] lnk, input logic [7:0] b);
        logic [ITEM_W-1:0] it;
        it = '0;
        it[ITEM_HDR_BIT]                = hdr;
        it[ITEM_LAST_BIT]               = last;
        it[ITEM_CLS_LSB +: 5]           = c;
        it[ITEM_UNREC_BIT]              = (c == CLS_UNRECOGNIZED);
        it[ITEM_VEND_BIT]               = (c == CLS_VENDOR);
        it[ITEM_MISP_BIT]               = misp;
        it[ITEM_LINK_LSB +: 8]          = lnk;
        it[ITEM_BYTE_LSB +: 8]          = b;
        return it;
    endfunction

    assign cls = ctw_classify(s_q.code);
    // wrong-kind format entries are flagged but still walked past
    assign misplaced = s_q.fmt_seen &&
        ((cls == CLS_GEOMETRY && !s_q.fmt_disk) || (cls == CLS_BYTE_ORDER && s_q.fmt_disk));
    assign term_type = (cls == CLS_PRODUCT_INFO) || (cls == CLS_ALT_STRINGS);
    // body ends at the link length whatever the content, or early at a terminator in a 15h or 16h tuple
    assign body_end  = (s_q.cnt + 8'h01 == s_q.link) || (term_type && rd_data == TERM_BYTE);

    // ------------------------------------------------------------------
    // walk sequencer
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            ST_IDLE: begin
                if (start) begin
                    s_d.pos      = '0;
                    s_d.addr     = '0;
                    s_d.req      = 1'b1;
                    s_d.busy     = 1'b1;
                    s_d.done     = 1'b0;
                    s_d.err      = 1'b0;
                    s_d.fmt_seen = 1'b0;
                    s_d.fmt_disk = 1'b0;
                    s_d.st       = ST_CODE;
                end
            end
            ST_CODE: begin
                if (rd_ack) begin
                    s_d.req  = 1'b0;
                    s_d.code = rd_data;
                    if (rd_data == CODE_END_OF_CHAIN) begin
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.st   = ST_IDLE;
                    end else if (rd_data == CODE_NULL_ENTRY) begin
                        s_d.pos = s_q.pos + 1'b1;
                        if (s_d.pos >= POS_W'(MAX_BYTES)) begin
                            s_d.err  = 1'b1;
                            s_d.busy = 1'b0;
                            s_d.done = 1'b1;
                            s_d.st   = ST_IDLE;
                        end else begin
                            s_d.addr = card_addr(s_d.pos);
                            s_d.req  = 1'b1;
                        end
                    end else begin
                        s_d.pos  = s_q.pos + 1'b1;
                        s_d.addr = card_addr(s_d.pos);
                        s_d.req  = 1'b1;
                        s_d.st   = ST_LINK;
                    end
                end
            end
            ST_LINK: begin
                if (rd_ack) begin
                    s_d.req        = 1'b0;
                    s_d.link       = rd_data;
                    s_d.cnt        = '0;
                    s_d.word       = '0;
                    s_d.nxt        = s_q.pos + 1'b1 + POS_W'(rd_data);
                    s_d.item       = make_item(1'b1, rd_data == LINK_LAST, cls, misplaced, rd_data, s_q.code);
                    s_d.item_valid = 1'b1;
                    s_d.st         = ST_HDR;
                end
            end
            ST_HDR: begin
                if (buf_ready) begin
                    s_d.item_valid = 1'b0;
                    if (s_q.link == LINK_LAST) begin
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.st   = ST_IDLE;
                    end else if (s_q.nxt >= POS_W'(MAX_BYTES)) begin
                        s_d.err  = 1'b1;
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.st   = ST_IDLE;
                    end else if (s_q.link == 8'h00) begin
                        s_d.pos  = s_q.nxt;
                        s_d.addr = card_addr(s_q.nxt);
                        s_d.req  = 1'b1;
                        s_d.st   = ST_CODE;
                    end else begin
                        s_d.pos  = s_q.pos + 1'b1;
                        s_d.addr = card_addr(s_d.pos);
                        s_d.req  = 1'b1;
                        s_d.st   = ST_BODY;
                    end
                end
            end
            ST_BODY: begin
                if (rd_ack) begin
                    s_d.req = 1'b0;
                    if (s_q.cnt == 8'h00) begin
                        s_d.word[7:0] = rd_data;
                        if (cls == CLS_FORMAT) begin
                            s_d.fmt_seen = 1'b1;
                            s_d.fmt_disk = (rd_data == FMT_DISK_TYPE);
                        end
                    end else if (s_q.cnt == 8'h01) begin
                        s_d.word[15:8] = rd_data;
                    end
                    s_d.item       = make_item(1'b0, body_end, cls, misplaced, s_q.link, rd_data);
                    s_d.item_valid = 1'b1;
                    s_d.cnt        = s_q.cnt + 8'h01;
                    s_d.st         = ST_BPUSH;
                end
            end
            ST_BPUSH: begin
                if (buf_ready) begin
                    s_d.item_valid = 1'b0;
                    if (s_q.item[ITEM_LAST_BIT]) begin
                        s_d.pos  = s_q.nxt;
                        s_d.addr = card_addr(s_q.nxt);
                        s_d.req  = 1'b1;
                        s_d.st   = ST_CODE;
                    end else begin
                        s_d.pos  = s_q.pos + 1'b1;
                        s_d.addr = card_addr(s_d.pos);
                        s_d.req  = 1'b1;
                        s_d.st   = ST_BODY;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // output buffer; a stalled consumer holds the walk in HDR or BPUSH
    // ------------------------------------------------------------------
    ctw_skid #(
        .W (ITEM_W)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .in_valid  (s_q.item_valid),
        .in_ready  (buf_ready),
        .in_data   (s_q.item),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buf_data)
    );

    assign out_hdr          = buf_data[ITEM_HDR_BIT];
    assign out_last         = buf_data[ITEM_LAST_BIT];
    assign out_class        = ctw_class_t'(buf_data[ITEM_CLS_LSB +: 5]);
    assign out_unrecognized = buf_data[ITEM_UNREC_BIT];
    assign out_vendor       = buf_data[ITEM_VEND_BIT];
    assign out_misplaced    = buf_data[ITEM_MISP_BIT];
    assign out_link         = buf_data[ITEM_LINK_LSB +: 8];
    assign out_byte         = buf_data[ITEM_BYTE_LSB +: 8];
    assign field_word       = s_q.word;
    assign rd_req           = s_q.req;
    assign rd_addr          = s_q.addr;
    assign busy             = s_q.busy;
    assign done             = s_q.done;
    assign chain_error      = s_q.err;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    start_zero_a: assert property (ce && s_q.st == ST_IDLE && start |=> rd_req && rd_addr == '0)
        else $error("walk did not start at address zero");
    end_code_a: assert property (ce && s_q.st == ST_CODE && rd_ack && rd_data == CODE_END_OF_CHAIN
        |=> done && !busy && !rd_req)
        else $error("end code did not stop the walk");
    even_addr_a: assert property (rd_req |-> rd_addr[0] == 1'b0)
        else $error("odd attribute address fetched");
    null_skip_a: assert property (ce && s_q.st == ST_CODE && rd_ack && rd_data == CODE_NULL_ENTRY
        && s_q.pos + 1'b1 < POS_W'(MAX_BYTES) |=> s_q.st == ST_CODE && rd_addr == $past(rd_addr) + ADDR_W'(2))
        else $error("null entry not skipped by one byte");
    body_bound_a: assert property (s_q.st == ST_BPUSH |-> s_q.cnt <= s_q.link)
        else $error("body read past link length");
    link_last_a: assert property (ce && s_q.st == ST_HDR && buf_ready && s_q.link == LINK_LAST
        |=> done && !busy)
        else $error("last-link tuple did not end the walk");
    size_err_a: assert property (chain_error |-> !busy && done)
        else $error("error flag while walking");
    word_lsb_a: assert property (ce && s_q.st == ST_BODY && rd_ack && s_q.cnt == 8'h00
        |=> field_word[7:0] == $past(rd_data))
        else $error("low field byte not taken first");
    vendor_flag_a: assert property (out_valid && out_hdr && out_byte >= CODE_VENDOR_LO
        |-> out_vendor && !out_unrecognized)
        else $error("vendor code not flagged");
    reserved_flag_a: assert property (out_valid && out_hdr && out_byte >= 8'h1A && out_byte <= 8'h3F
        |-> out_unrecognized)
        else $error("reserved code not flagged");
    next_pos_a: assert property (ce && s_q.st == ST_BPUSH && buf_ready && s_q.item[ITEM_LAST_BIT]
        |=> rd_req && rd_addr == card_addr($past(s_q.nxt)))
        else $error("next tuple address wrong");

    walk_done_c: cover property (done && !chain_error);
    stall_c: cover property (s_q.st == ST_BPUSH && !buf_ready);
    misplaced_c: cover property (out_valid && out_misplaced);
    overflow_c: cover property (chain_error);

endmodule
`default_nettype wire

// File: testbench/ctw_mem.sv
// card memory model answering the walker's byte reads
`timescale 1ns/1ns
`default_nettype none
module ctw_mem (
    input  wire logic        clk,
    input  wire logic        rd_req,
    input  wire logic [25:0] rd_addr,
    output logic             rd_ack,
    output logic [7:0]       rd_data
);
    logic [7:0] mem [0:63];
    int         dly = 0;
    initial begin
        rd_ack  = 1'b0;
        rd_data = 8'h5A;
    end
    // waits 0 to 3 cycles; data scrambles once released so stale bytes show
    always @(negedge clk) begin
        if (rd_ack) begin
            rd_ack  <= 1'b0;
            rd_data <= ~rd_data;
        end else if (rd_req && dly != 0) begin
            dly <= dly - 1;
        end else if (rd_req) begin
            rd_ack  <= 1'b1;
            rd_data <= mem[rd_addr[6:1]];
            dly     <= $random & 3;
        end
    end
endmodule
`default_nettype wire

// File: testbench/ctw_walker_tb.sv
// self-checking bench for the tuple walker
`timescale 1ns/1ns
`default_nettype none
module ctw_walker_tb;
    localparam int MAXB = 64;
    logic        clk = 0, reset = 1, start = 0, out_ready = 0;
    logic        rd_req, rd_ack, out_valid, out_hdr, out_last, out_vendor, busy, done, chain_error;
    logic        out_unrecognized, out_misplaced, u, m, fs, fd;
    logic [25:0] rd_addr;
    logic [7:0]  rd_data, out_byte, out_link, c, b;
    logic [20:0] q[$];
    int          n_errors = 0, check_count = 0, cyc = 0, seed = 28372, p, l, rdy = 8;
    ctw_walker #(.MAX_BYTES(MAXB)) u_ctw_walker (.clk(clk), .reset(reset), .ce(1'b1), .start(start),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_hdr(out_hdr), .out_last(out_last), .out_class(),
        .out_unrecognized(out_unrecognized), .out_vendor(out_vendor), .out_misplaced(out_misplaced),
        .out_link(out_link), .out_byte(out_byte), .field_word(),
        .busy(busy), .done(done), .chain_error(chain_error));
    ctw_mem u_ctw_mem (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(negedge clk) out_ready <= ($random(seed) & 7) < rdy;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            n_errors++;
            end_sim();
        end else if (out_valid === 1'b1 && out_ready) begin
            chk({out_hdr, out_last, out_hdr & out_vendor, out_hdr & out_unrecognized, out_misplaced, out_link,
                out_byte}, q.size() ? q.pop_front() : 21'h1FFFFF, "item");
        end
    end
    // reference walk over the packed bytes: {hdr, last, vendor, unrec, misplaced, link, byte}
    task automatic expect_walk(output logic err);
        p = 0;
        err = 0;
        fs = 0;
        fd = 0;
        forever begin
            if (p >= MAXB) begin
                err = 1;
                break;
            end
            c = u_ctw_mem.mem[p];
            if (c == 8'h00) begin
                p++;
                continue;
            end
            if (c == 8'hFF) break;
            l = u_ctw_mem.mem[p+1];
            u = (c >= 8'h08 && c <= 8'h0F) || (c >= 8'h1A && c <= 8'h3F) || (c >= 8'h47 && c <= 8'h7F);
            m = fs && ((c == 8'h42 && !fd) || (c == 8'h43 && fd));
            q.push_back({1'b1, l == 255, c >= 8'h80, u, m, l[7:0], c});
            if (l == 255) break;
            for (int i = 0; i < l; i++) begin
                b = u_ctw_mem.mem[p+2+i];
                if (i == 0 && c == 8'h41) begin
                    fs = 1;
                    fd = (b == 8'h00);
                end
                q.push_back({1'b0, i == l-1 || (b == 8'hFF && (c == 8'h15 || c == 8'h16)), 2'b00, m, l[7:0], b});
                if (b == 8'hFF && (c == 8'h15 || c == 8'h16)) break;
            end
            p += 2 + l;
        end
    endtask
    task automatic run(input string name);
        logic e;
        expect_walk(e);
        @(negedge clk) start = 1;
        @(negedge clk) start = 0;
        @(negedge clk);
        while (done !== 1'b1 || out_valid === 1'b1 || q.size() != 0) @(negedge clk);
        chk({20'h00000, chain_error}, {20'h00000, e}, name);
        $display("test %s finished", name);
    endtask
    localparam logic [7:0] HAND [18] = '{8'h01, 8'h00, 8'h00, 8'h15, 8'h04, 8'h41, 8'hFF, 8'h42, 8'h43,
        8'h80, 8'h01, 8'hAA, 8'h20, 8'h01, 8'hBB, 8'h17, 8'hFF, 8'h01};
    // memory-like format, then a geometry entry (misplaced) and a byte-order entry (allowed)
    localparam logic [7:0] FMT [8] = '{8'h41, 8'h01, 8'h01, 8'h42, 8'h00, 8'h43, 8'h00, 8'hFF};
    initial begin
        for (int i = 0; i < MAXB; i++) u_ctw_mem.mem[i] = 8'h00;
        repeat (8) @(posedge clk);
        @(negedge clk) reset = 0;
        run("nulls");
        for (int i = 0; i < 18; i++) u_ctw_mem.mem[i] = HAND[i];
        rdy = 1;
        run("hand");
        for (int i = 0; i < 8; i++) u_ctw_mem.mem[i] = FMT[i];
        run("format");
        for (int t = 0; t < 30; t++) begin
            for (int i = 0; i < MAXB; i++) u_ctw_mem.mem[i] = 8'hFF;
            p = 0;
            while (p < 48) begin
                c = $random(seed);
                l = $random(seed) & 3;
                u_ctw_mem.mem[p] = (c == 8'hFF) ? 8'h16 : c;
                if (c == 8'h00) p++;
                else begin
                    u_ctw_mem.mem[p+1] = l[7:0];
                    for (int i = 0; i < l; i++) u_ctw_mem.mem[p+2+i] = $random(seed);
                    p += 2 + l;
                end
            end
            if (t % 2) u_ctw_mem.mem[p+1] = 8'hFF;
            rdy = 1 + t % 8;
            run("random");
        end
        end_sim();
    end
endmodule
`default_nettype wire
